/* File: rtl/rlhc_regs.svh */
/*
 Constants of the reference-loss hold control: serial word layout,
 configuration fields, reset values and timing counts.
 Assumes a 25 MHz system clock on both ends.
*/
`ifndef RLHC_REGS_SVH
`define RLHC_REGS_SVH

// ---------------------------------------------------------------
// Serial configuration frame
// ---------------------------------------------------------------
`define RLHC_DATA_W 16
`define RLHC_ADDR_W 2
`define RLHC_FRAME_W 18
`define RLHC_ADDR_LSB 16
`define RLHC_ADDR_MSB 17
`define RLHC_NUM_WORDS 4
`define RLHC_BITCNT_W 5
`define RLHC_LAST_BIT 5'h11

// ---------------------------------------------------------------
// Configuration fields
// ---------------------------------------------------------------
`define RLHC_HOLD_WORD 2'h2
`define RLHC_HOLD_EN_BIT 2
`define RLHC_PUMP_OFF_BIT 3
`define RLHC_WORD_RST 16'h0000

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define RLHC_CLK_NS 40
`define RLHC_LOCK_CYCLES 3'h5
`define RLHC_LOCK_CNT_W 3
// Longest reference gap before the status output drops
`define RLHC_REF_LOSS_NS 640
`define RLHC_REF_LOSS_CYC ((`RLHC_REF_LOSS_NS) / (`RLHC_CLK_NS))
`define RLHC_LOSS_CNT_W 5
// Least half period of the serial clock
`define RLHC_SCLK_HALF_NS 80
`define RLHC_SCLK_HALF_CYC \
   (((`RLHC_SCLK_HALF_NS) + (`RLHC_CLK_NS) - 1) / (`RLHC_CLK_NS))
`define RLHC_DIV_W 3

`endif

/* File: rtl/rlhc_pkg.sv */
/*
 Types shared by both ends of the reference-loss hold control.
 Assumes rlhc_regs.svh for the widths.
*/
`include "rlhc_regs.svh"

package rlhc_pkg;

   // Device hold state machine
   typedef enum logic [1:0] {
      RLHC_ACQUIRE = 2'b00,
      RLHC_LOCKED  = 2'b01,
      RLHC_HOLD    = 2'b10
   } rlhc_dev_state_t;

   // Controller serial sequencer
   typedef enum logic [1:0] {
      RLHC_IDLE  = 2'b00,
      RLHC_SHIFT = 2'b01,
      RLHC_LATCH = 2'b10
   } rlhc_ser_state_t;

   typedef logic [`RLHC_DATA_W-1:0] rlhc_word_t;
   typedef logic [`RLHC_FRAME_W-1:0] rlhc_frame_t;
   typedef rlhc_word_t [`RLHC_NUM_WORDS-1:0] rlhc_cfg_t;

endpackage

/* File: rtl/rlhc_if.sv */
/*
 Link between the synthesizer and its controller: three-wire serial
 configuration port and the reference-present status pin.
 Assumes both ends run on the same clk_sys.
*/
`timescale 1ns/100ps

interface rlhc_if;
   logic ser_clk;
   logic ser_data;
   logic ser_latch;
   logic ref_present;

   modport dev (
      input ser_clk,
      input ser_data,
      input ser_latch,
      output ref_present
   );

   modport ctl (
      output ser_clk,
      output ser_data,
      output ser_latch,
      input ref_present
   );
endinterface

/* File: rtl/rlhc_device.sv */
/*
 Synthesizer end: serial configuration words, lock detection, fast
 missing-reference hold, reference-present status and the tri-state
 control of the charge pump output.
 Assumes the reference and feedback edges arrive as one-cycle pulses
 synchronous to clk_sys, and the link inputs are synchronous too.
*/
`timescale 1ns/100ps
`include "rlhc_regs.svh"

module rlhc_device
   import rlhc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   rlhc_if.dev link,
   input wire logic ref_edge,
   input wire logic fb_edge,
   input wire logic in_window,
   input wire logic pfd_up,
   input wire logic pfd_dn,
   output logic pump_output_up,
   output logic pump_output_dn,
   output logic pump_output_oe_n,
   output logic locked,
   output logic hold_active,
   output logic hold_en,
   output logic configured
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   rlhc_cfg_t cfg_r;
   rlhc_frame_t shift_r;
   logic sclk_q_r;
   logic latch_q_r;
   logic cfg_done_r;
   rlhc_dev_state_t state_r;
   rlhc_dev_state_t state_nxt;
   logic [`RLHC_LOCK_CNT_W-1:0] lock_cnt_r;
   logic ref_seen_r;
   logic ref_seen;
   logic miss;
   logic [`RLHC_LOSS_CNT_W-1:0] loss_cnt_r;
   logic ref_ok_r;
   logic status_r;
   logic pump_off;
   logic pump_hiz;
   logic up_r;
   logic dn_r;
   logic oe_n_r;
   logic sclk_rise;
   logic latch_rise;

   // Word address field of a received frame
   function automatic logic [`RLHC_ADDR_W-1:0] frame_addr(
      input rlhc_frame_t f
   );
      frame_addr = f[`RLHC_ADDR_MSB:`RLHC_ADDR_LSB];
   endfunction

   // Selects one field bit of the hold word
   function automatic logic hold_bit(
      input rlhc_cfg_t c,
      input int unsigned pos
   );
      hold_bit = c[`RLHC_HOLD_WORD][pos];
   endfunction

   // ---------------------------------------------------------------
   // Serial configuration port
   // ---------------------------------------------------------------

   // Edge history of the link strobes
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sclk_q_r <= 1'b0;
         latch_q_r <= 1'b0;
      end else begin
         sclk_q_r <= link.ser_clk;
         latch_q_r <= link.ser_latch;
      end
   end

   assign sclk_rise = link.ser_clk & ~sclk_q_r;
   assign latch_rise = link.ser_latch & ~latch_q_r;

   // Data shifts in MSB first on each serial clock rise
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         shift_r <= '0;
      end else if (sclk_rise) begin
         shift_r <= {shift_r[`RLHC_FRAME_W-2:0], link.ser_data};
      end
   end

   // The latch strobe commits the last frame; extra bits simply
   // push older ones out, so only the final eighteen count
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cfg_r <= {`RLHC_NUM_WORDS{`RLHC_WORD_RST}};
      end else if (latch_rise) begin
         cfg_r[frame_addr(shift_r)] <= shift_r[`RLHC_DATA_W-1:0];
      end
   end

   // Configured once any word has been loaded after power-up
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cfg_done_r <= 1'b0;
      end else if (latch_rise) begin
         cfg_done_r <= 1'b1;
      end
   end

   assign hold_en = hold_bit(cfg_r, `RLHC_HOLD_EN_BIT);
   assign pump_off = hold_bit(cfg_r, `RLHC_PUMP_OFF_BIT);
   assign configured = cfg_done_r;

   // ---------------------------------------------------------------
   // Fast missing-reference detection
   // ---------------------------------------------------------------

   // A reference edge in the same cycle as the feedback edge counts
   // for the current period through ref_seen; in ref_seen_r the clear wins
   assign ref_seen = ref_seen_r | ref_edge;
   assign miss = fb_edge & ~ref_seen;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ref_seen_r <= 1'b0;
      end else if (fb_edge) begin
         ref_seen_r <= 1'b0;
      end else if (ref_edge) begin
         ref_seen_r <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Hold state machine
   // ---------------------------------------------------------------

   // Successive in-window feedback cycles; an out-of-window edge or forced pump
   // off restarts the count so lock is always earned afresh
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         lock_cnt_r <= '0;
      end else if (state_r != RLHC_ACQUIRE || pump_off) begin
         lock_cnt_r <= '0;
      end else if (fb_edge) begin
         if (in_window) begin
            lock_cnt_r <= lock_cnt_r + 1'b1;
         end else begin
            lock_cnt_r <= '0;
         end
      end
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         RLHC_ACQUIRE: begin
            if (!pump_off && fb_edge && in_window &&
                lock_cnt_r == `RLHC_LOCK_CYCLES - 1'b1) begin
               state_nxt = RLHC_LOCKED;
            end
         end
         RLHC_LOCKED: begin
            if (pump_off) begin
               state_nxt = RLHC_ACQUIRE;
            end else if (hold_en && miss) begin
               state_nxt = RLHC_HOLD;
            end
         end
         RLHC_HOLD: begin
            // Reference back or pump forced off: relock from scratch
            if (ref_edge || pump_off) begin
               state_nxt = RLHC_ACQUIRE;
            end
         end
         default: begin
            state_nxt = RLHC_ACQUIRE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_r <= RLHC_ACQUIRE;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign locked = (state_r == RLHC_LOCKED);
   assign hold_active = (state_r == RLHC_HOLD);

   // ---------------------------------------------------------------
   // Reference-present status
   // ---------------------------------------------------------------

   // Slow detector: tolerant of jitter but blind to a single miss,
   // which is why the fast path above exists
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         loss_cnt_r <= '0;
         ref_ok_r <= 1'b0;
      end else if (ref_edge) begin
         loss_cnt_r <= '0;
         ref_ok_r <= 1'b1;
      end else if (loss_cnt_r ==
                   `RLHC_LOSS_CNT_W'(`RLHC_REF_LOSS_CYC - 1)) begin
         ref_ok_r <= 1'b0;
      end else begin
         loss_cnt_r <= loss_cnt_r + 1'b1;
      end
   end

   // Status reflects the reference, not lock, so the controller
   // can see it return while the pump is still off
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         status_r <= 1'b0;
      end else begin
         status_r <= ref_ok_r & cfg_done_r;
      end
   end

   assign link.ref_present = status_r;

   // ---------------------------------------------------------------
   // Charge pump output
   // ---------------------------------------------------------------

   // Tri-state by the hold machine or by the controller's command
   assign pump_hiz = (state_nxt == RLHC_HOLD) | pump_off;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         up_r <= 1'b0;
         dn_r <= 1'b0;
         oe_n_r <= 1'b1;
      end else begin
         up_r <= pfd_up & ~pump_hiz;
         dn_r <= pfd_dn & ~pump_hiz;
         oe_n_r <= pump_hiz;
      end
   end

   assign pump_output_up = up_r;
   assign pump_output_dn = dn_r;
   assign pump_output_oe_n = oe_n_r;

endmodule

/* File: rtl/rlhc_ctrl.sv */
/*
 Controller end: loads the configuration after reset, then watches
 the reference-present pin and turns the charge pump off and on
 again over the serial port.
 Assumes the device samples serial data on the serial clock rise.
*/
`timescale 1ns/100ps
`include "rlhc_regs.svh"

module rlhc_ctrl
   import rlhc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   rlhc_if.ctl link,
   input rlhc_cfg_t cfg_init,
   output logic cfg_done,
   output logic pump_off,
   output logic busy
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   rlhc_ser_state_t ser_r;
   logic [`RLHC_DIV_W-1:0] div_r;
   logic tick;
   logic [`RLHC_BITCNT_W-1:0] bit_r;
   rlhc_frame_t frame_r;
   logic sclk_r;
   logic latch_r;
   logic [`RLHC_ADDR_W:0] load_r;
   logic st_meta_r;
   logic st_sync_r;
   logic st_prev_r;
   logic want_off_r;
   logic sent_off_r;
   logic start_load;
   logic start_pump;

   // Builds a frame, forcing the pump bit of the hold word
   function automatic rlhc_frame_t make_frame(
      input logic [`RLHC_ADDR_W-1:0] a,
      input rlhc_word_t w,
      input logic off
   );
      rlhc_word_t d;
      d = w;
      if (a == `RLHC_HOLD_WORD) begin
         d[`RLHC_PUMP_OFF_BIT] = off;
      end
      make_frame = {a, d};
   endfunction

   // ---------------------------------------------------------------
   // Status pin watch
   // ---------------------------------------------------------------

   // Two-stage synchroniser, then an edge memory on the clean stage
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_meta_r <= 1'b0;
         st_sync_r <= 1'b0;
         st_prev_r <= 1'b0;
      end else begin
         st_meta_r <= link.ref_present;
         st_sync_r <= st_meta_r;
         st_prev_r <= st_sync_r;
      end
   end

   // Edges set the wanted pump state; a frame is sent only when it
   // differs from the last sent one, so each edge costs at most one write.
   // Gated by the load walk, not by idle, so an edge that arrives
   // while a frame is on the wire is held rather than lost
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         want_off_r <= 1'b0;
      end else if (load_r[`RLHC_ADDR_W] && st_prev_r && !st_sync_r) begin
         want_off_r <= 1'b1;
      end else if (load_r[`RLHC_ADDR_W] && !st_prev_r && st_sync_r) begin
         want_off_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Sequencing of frames
   // ---------------------------------------------------------------
   assign start_load = (ser_r == RLHC_IDLE) && !load_r[`RLHC_ADDR_W];
   assign start_pump = (ser_r == RLHC_IDLE) && load_r[`RLHC_ADDR_W] &&
                       (want_off_r != sent_off_r);

   // Power-up load walks words 0 to 3 once
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         load_r <= '0;
      end else if (start_load) begin
         load_r <= load_r + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sent_off_r <= 1'b0;
      end else if (start_pump) begin
         sent_off_r <= want_off_r;
      end
   end

   // Half-period divider for the serial clock
   always_ff @(posedge clk_sys) begin
      if (srst || ser_r == RLHC_IDLE) begin
         div_r <= '0;
      end else if (tick) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end

   assign tick = (div_r == `RLHC_DIV_W'(`RLHC_SCLK_HALF_CYC - 1));

   // Data changes with the clock low and is held over the rise
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ser_r <= RLHC_IDLE;
         bit_r <= '0;
         frame_r <= '0;
         sclk_r <= 1'b0;
         latch_r <= 1'b0;
      end else begin
         case (ser_r)
            RLHC_IDLE: begin
               bit_r <= '0;
               if (start_load) begin
                  frame_r <= make_frame(load_r[`RLHC_ADDR_W-1:0],
                     cfg_init[load_r[`RLHC_ADDR_W-1:0]], 1'b0);
                  ser_r <= RLHC_SHIFT;
               end else if (start_pump) begin
                  frame_r <= make_frame(`RLHC_HOLD_WORD,
                     cfg_init[`RLHC_HOLD_WORD], want_off_r);
                  ser_r <= RLHC_SHIFT;
               end
            end
            RLHC_SHIFT: begin
               if (tick && !sclk_r) begin
                  sclk_r <= 1'b1;
               end else if (tick) begin
                  sclk_r <= 1'b0;
                  frame_r <= {frame_r[`RLHC_FRAME_W-2:0], 1'b0};
                  bit_r <= bit_r + 1'b1;
                  if (bit_r == `RLHC_LAST_BIT) begin
                     ser_r <= RLHC_LATCH;
                  end
               end
            end
            RLHC_LATCH: begin
               if (tick && !latch_r) begin
                  latch_r <= 1'b1;
               end else if (tick) begin
                  latch_r <= 1'b0;
                  ser_r <= RLHC_IDLE;
               end
            end
            default: begin
               ser_r <= RLHC_IDLE;
            end
         endcase
      end
   end

   assign link.ser_clk = sclk_r;
   assign link.ser_data = frame_r[`RLHC_FRAME_W-1];
   assign link.ser_latch = latch_r;
   // Lock is reacquired by the device itself after re-enable
   assign cfg_done = load_r[`RLHC_ADDR_W] && (ser_r == RLHC_IDLE);
   assign pump_off = sent_off_r;
   assign busy = (ser_r != RLHC_IDLE);

endmodule

/* File: sim/rlhc_monitor.sv */
/*
 Checker for the link between the two ends: serial framing and the
 answer of the controller to edges of the reference-present pin.
 Assumes one clk_sys domain and sync reset srst, active high.
*/
`timescale 1ns/100ps

module rlhc_monitor (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_latch,
   input wire logic ref_present
);
   logic clk_q_r;
   logic latch_q_r;
   logic ref_q_r;
   logic seen_edge_r;
   logic fell_seen_r;
   logic [4:0] bit_cnt_r;
   logic [2:0] lat_cnt_r;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   // -------------------------------------------------------------
   // Helper logic
   // -------------------------------------------------------------
   // Delayed copies for edge detection
   always_ff @(posedge clk_sys) begin
      clk_q_r <= srst ? 1'b0 : ser_clk;
      latch_q_r <= srst ? 1'b0 : ser_latch;
      ref_q_r <= srst ? 1'b0 : ref_present;
   end

   // Clock rises since the last commit
   always_ff @(posedge clk_sys) begin
      if (srst || (latch_q_r && !ser_latch)) begin
         bit_cnt_r <= 5'h00;
      end else if (ser_clk && !clk_q_r) begin
         bit_cnt_r <= bit_cnt_r + 5'h01;
      end
   end

   // Commits since the last status edge; power-up frames not counted
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         lat_cnt_r <= 3'h0;
         seen_edge_r <= 1'b0;
      end else if (ref_present != ref_q_r) begin
         lat_cnt_r <= 3'h0;
         seen_edge_r <= 1'b1;
      end else if (ser_latch && !latch_q_r) begin
         lat_cnt_r <= lat_cnt_r + 3'h1;
      end
   end

   // The first rise after power-up turns nothing back on, so only a
   // rise that follows a fall calls for a frame
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fell_seen_r <= 1'b0;
      end else if (!ref_present && ref_q_r) begin
         fell_seen_r <= 1'b1;
      end
   end

   // -------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------
   sequence s_high2(sig);
      sig ##1 !sig;
   endsequence

   property p_clk_high2;
      $rose(ser_clk) |=> s_high2(ser_clk);
   endproperty
   a_clk_high2: assert property (p_clk_high2)
      else $error("serial clock high time wrong");

   property p_clk_low2;
      $fell(ser_clk) |=> !ser_clk;
   endproperty
   a_clk_low2: assert property (p_clk_low2)
      else $error("serial clock low time too short");

   property p_data_stable;
      ser_clk |-> $stable(ser_data);
   endproperty
   a_data_stable: assert property (p_data_stable)
      else $error("serial data moved while clock high");

   property p_latch_high2;
      $rose(ser_latch) |=> s_high2(ser_latch);
   endproperty
   a_latch_high2: assert property (p_latch_high2)
      else $error("commit strobe width wrong");

   property p_no_overlap;
      !(ser_clk && ser_latch);
   endproperty
   a_no_overlap: assert property (p_no_overlap)
      else $error("clock and commit strobe high together");

   property p_bits18;
      $rose(ser_latch) |-> bit_cnt_r == 5'h12;
   endproperty
   a_bits18: assert property (p_bits18)
      else $error("frame without eighteen bits");

   property p_fall_frame;
      $fell(ref_present) |-> ##[1:200] $rose(ser_latch);
   endproperty
   a_fall_frame: assert property (p_fall_frame)
      else $error("no frame after status fall");

   property p_rise_frame;
      $rose(ref_present) && fell_seen_r |-> ##[1:200] $rose(ser_latch);
   endproperty
   a_rise_frame: assert property (p_rise_frame)
      else $error("no frame after status rise");

   property p_one_frame;
      seen_edge_r && $rose(ser_latch) |-> lat_cnt_r == 3'h0;
   endproperty
   a_one_frame: assert property (p_one_frame)
      else $error("second frame for one status edge");
endmodule

/* File: sim/rlhc_tb.sv */
/*
 Testbench joining device and controller across the link: power-up
 load, lock, outage, pump hold and recovery.
 Assumes the link and the pulse inputs are synchronous to clk_sys.
*/
`timescale 1ns/100ps

module rlhc_tb
   import rlhc_pkg::*;
;
   typedef struct packed {logic [1:0] pfd; logic [1:0] pump;} rlhc_row_t;
   logic clk_sys;
   logic srst;
   logic ref_edge, fb_edge, in_window, pfd_up, pfd_dn, run_ref, run_fb;
   logic pump_output_up, pump_output_dn, pump_output_oe_n;
   logic locked, hold_active, hold_en, configured;
   logic cfg_done, pump_off, busy, sclk_q, slat_q;
   logic [1:0] phase;
   rlhc_cfg_t cfg_init;
   rlhc_frame_t shift_r, frame_r;
   rlhc_row_t rows [4];
   int n_frames, n_mismatch, n_checks, k, n0;

   rlhc_if i_rlhc_if ();
   rlhc_device i_rlhc_device (.clk_sys(clk_sys), .srst(srst),
      .link(i_rlhc_if.dev), .ref_edge(ref_edge), .fb_edge(fb_edge),
      .in_window(in_window), .pfd_up(pfd_up), .pfd_dn(pfd_dn),
      .pump_output_up(pump_output_up), .pump_output_dn(pump_output_dn),
      .pump_output_oe_n(pump_output_oe_n), .locked(locked),
      .hold_active(hold_active), .hold_en(hold_en),
      .configured(configured));
   rlhc_ctrl i_rlhc_ctrl (.clk_sys(clk_sys), .srst(srst),
      .link(i_rlhc_if.ctl), .cfg_init(cfg_init), .cfg_done(cfg_done),
      .pump_off(pump_off), .busy(busy));
   rlhc_monitor i_rlhc_monitor (.clk_sys(clk_sys), .srst(srst),
      .ser_clk(i_rlhc_if.ser_clk), .ser_data(i_rlhc_if.ser_data),
      .ser_latch(i_rlhc_if.ser_latch),
      .ref_present(i_rlhc_if.ref_present));

   // ------------------------------------------------------------
   // Clock, pulses and frame capture
   // ------------------------------------------------------------
   always #20 clk_sys = ~clk_sys;

   // Reference and feedback pulses every fourth cycle, in phase
   always @(negedge clk_sys) begin
      phase <= phase + 2'h1;
      ref_edge <= run_ref && (phase == 2'h0);
      fb_edge <= run_fb && (phase == 2'h0);
   end

   // Rebuild each frame off the wire, independent of the device
   always @(posedge clk_sys) begin
      sclk_q <= i_rlhc_if.ser_clk;
      slat_q <= i_rlhc_if.ser_latch;
      if (i_rlhc_if.ser_clk && !sclk_q) begin
         shift_r <= {shift_r[16:0], i_rlhc_if.ser_data};
      end
      if (i_rlhc_if.ser_latch && !slat_q) begin
         frame_r <= shift_r;
         n_frames <= n_frames + 1;
      end
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input rlhc_frame_t got, input rlhc_frame_t exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Watchdog: the whole sequence needs about 600 cycles
   initial begin
      repeat (6000) @(posedge clk_sys);
      n_mismatch++;
      finish_test();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      srst = 1'b1;
      {ref_edge, fb_edge, pfd_up, pfd_dn, run_ref, run_fb} = 6'h00;
      in_window = 1'b1;
      phase = 2'h0;
      n_frames = 0;
      cfg_init = {16'h00A5, 16'h0004, 16'h5A3C, 16'h1234};
      rows = '{'{2'h0, 2'h0}, '{2'h2, 2'h2}, '{2'h1, 2'h1}, '{2'h3, 2'h3}};
      repeat (20) @(negedge clk_sys);
      check(pump_output_oe_n, 1'b1);
      check(i_rlhc_if.ref_present, 1'b0);
      srst = 1'b0;
      // Power-up load of all four words
      for (k = 0; k < 600 && cfg_done !== 1'b1; k++) @(negedge clk_sys);
      check(n_frames, 4);
      check(frame_r, {2'h3, cfg_init[3]});
      check(hold_en, 1'b1);
      check(configured, 1'b1);
      run_ref = 1'b1;
      run_fb = 1'b1;
      for (k = 0; k < 100 && locked !== 1'b1; k++) @(negedge clk_sys);
      check(locked, 1'b1);
      check(pump_output_oe_n, 1'b0);
      check(i_rlhc_if.ref_present, 1'b1);
      // Pump follows the phase detector while locked
      for (k = 0; k < 4; k++) begin
         {pfd_up, pfd_dn} = rows[k].pfd;
         @(negedge clk_sys);
         check({pump_output_up, pump_output_dn}, rows[k].pump);
      end
      // Outage: fast hold before the status pin drops
      n0 = n_frames;
      run_ref = 1'b0;
      pfd_up = 1'b1;
      for (k = 0; k < 10 && hold_active !== 1'b1; k++) @(negedge clk_sys);
      @(negedge clk_sys);
      check(hold_active, 1'b1);
      check(pump_output_oe_n, 1'b1);
      check(pump_output_up, 1'b0);
      check(pump_output_dn, 1'b0);
      check(i_rlhc_if.ref_present, 1'b1);
      for (k = 0; k < 300 && !(pump_off === 1'b1 && busy === 1'b0); k++)
         @(negedge clk_sys);
      check(i_rlhc_if.ref_present, 1'b0);
      check(pump_off, 1'b1);
      check(frame_r, {2'h2, 16'h000C});
      check(n_frames, n0 + 1);
      // Reference returns: pump restored, fresh lock needed
      n0 = n_frames;
      run_ref = 1'b1;
      repeat (3) @(negedge clk_sys);
      check(locked, 1'b0);
      for (k = 0; k < 300 && !(pump_off === 1'b0 && busy === 1'b0); k++)
         @(negedge clk_sys);
      check(i_rlhc_if.ref_present, 1'b1);
      check(frame_r, {2'h2, 16'h0004});
      check(n_frames, n0 + 1);
      check(locked, 1'b0);
      for (k = 0; k < 100 && locked !== 1'b1; k++) @(negedge clk_sys);
      check(locked, 1'b1);
      check(pump_output_oe_n, 1'b0);
      finish_test();
   end
endmodule
